// ---- src/uart_baud_defs.svh ----
// register map, field positions, reset values and timing counts of the uart
`ifndef UART_BAUD_DEFS_SVH
`define UART_BAUD_DEFS_SVH

`define ADDR_DATA        4'h0
`define ADDR_FORMAT      4'h1
`define ADDR_PRESCALE    4'h2
`define ADDR_DIVISOR     4'h3
`define ADDR_STATUS      4'h4
`define ADDR_INT_STATUS  4'h5
`define ADDR_INT_MASK    4'h6
`define ADDR_WAKE_EN     4'h7
`define ADDR_WAKE_EDGE   4'h8

`define FMT_CHARL_LO     0
`define FMT_CHARL_HI     1
`define FMT_STOP2        2
`define FMT_PAR_EN       3
`define FMT_PAR_ODD      4
`define FMT_SYNC         5
`define FMT_XBIT9        6

`define ST_TRANSMIT_BUFFER_EMPTY_FLAG          0
`define ST_RBFL          1
`define ST_PERR          2
`define ST_FERR          3
`define ST_OVR           4
`define ST_RBIT9         5

`define INT_TX           0
`define INT_RX           1
`define INT_ERR          2
`define INT_WAKE         3

`define WAKE_RX_BIT      3

`define FORMAT_RST       8'h01
`define PRESCALE_RST     5'h01
`define DIVISOR_RST      8'h00

`define OVS_ASYNC        5'h10
`define OVS_SYNC         5'h02

`define CLK_PERIOD_NS    8
`define INSTR_CYCLE_NS   1000
`define WAKE_HOLD_TC     256
`define WAKE_HOLD_CYCLES \
    ((`WAKE_HOLD_TC * `INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- src/uart_baud_pkg.sv ----
// state types of the uart
package uart_baud_pkg;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_t;

    typedef enum logic {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_t;

    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_HOLD  = 2'b10
    } power_state_t;
endpackage : uart_baud_pkg

// ---- src/baud_tick_gen.sv ----
// fractional half-step prescaler followed by the baud divisor
`timescale 1ns/10ps
module baud_tick_gen (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [4:0] prescale_sel,
    input  wire logic [7:0] divisor,
    output logic            tick
);
    logic [5:0] acc;
    logic       pre_tick;
    logic [7:0] div_cnt;
    logic [6:0] sum;
    logic [6:0] limit;

    // factor is (code+1)/2: add two per clock, wrap at code+1
    assign sum   = {1'b0, acc} + 7'h02;
    assign limit = {2'b00, prescale_sel} + 7'h01;

    always_ff @(posedge clk) begin
        if (rst || prescale_sel == 5'h00) begin
            acc      <= 6'h00;
            pre_tick <= 1'b0;
        end else if (sum >= limit) begin
            acc      <= 6'(sum - limit);
            pre_tick <= 1'b1;
        end else begin
            acc      <= sum[5:0];
            pre_tick <= 1'b0;
        end
    end

    // divides by the programmed value plus one
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= 8'h00;
            tick    <= 1'b0;
        end else if (pre_tick) begin
            if (div_cnt >= divisor) begin
                div_cnt <= 8'h00;
                tick    <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 8'h01;
                tick    <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end
endmodule : baud_tick_gen

// ---- src/uart_baud_lowpower_loopback.sv ----
// uart with baud generation, low-power reinit, start-bit wake and loopback
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "uart_baud_defs.svh"
module uart_baud_lowpower_loopback #(
    parameter int WAKE_HOLD_CYCLES = `WAKE_HOLD_CYCLES
) (
    input  wire logic       SYS_CLK,
    input  wire logic       SYS_RST,
    input  wire logic [3:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WE,
    input  wire logic       REG_RE,
    output logic      [7:0] REG_RDATA,
    input  wire logic       SERIAL_RECEIVE_PIN,
    output logic            SERIAL_TRANSMIT_PIN,
    input  wire logic       LOWPOWER_ENTER,
    input  wire logic       LOWPOWER_HALT,
    input  wire logic       CRYSTAL_OSC,
    output logic            WAKE_UP,
    output logic            CODE_RUN,
    output logic            IRQ
);
    logic [7:0]  serial_format_control;
    logic [4:0]  prescale_sel;
    logic [7:0]  divisor;
    logic [3:0]  int_mask;
    logic [7:0]  wake_enable_register;
    logic [7:0]  wake_edge_register;
    logic [7:0]  transmit_holding_buffer;
    logic [11:0] transmit_shift_register;
    logic [7:0]  receive_holding_buffer;
    logic [9:0]  receive_shift_register;
    logic        transmit_buffer_empty_flag;
    logic        rbfl;
    logic        perr;
    logic        ferr;
    logic        ovr;
    logic        rbit9;
    logic [3:0]  int_status;
    logic        sample_tick;
    logic        rx_sync1;
    logic        rx_sync2;
    logic        rx_prev;
    logic        rx_in;
    uart_baud_pkg::tx_state_t    tx_state;
    uart_baud_pkg::rx_state_t    rx_state;
    uart_baud_pkg::power_state_t pwr_state;
    logic [4:0]  tx_phase;
    logic [3:0]  tx_left;
    logic [4:0]  rx_phase;
    logic [3:0]  rx_cnt;
    logic [15:0] hold_cnt;
    logic        hold_halt;
    logic        loopback;
    logic        par_en;
    logic [3:0]  dbits;
    logic [3:0]  nbits;
    logic [4:0]  ovs;
    logic [4:0]  half;
    logic        tx_bit_tick;
    logic        tx_load;
    logic        rx_deliver;
    logic [8:0]  data_mask;
    logic [11:0] next_frame;
    logic [3:0]  next_len;
    logic [9:0]  rx_word;
    logic        rx_par_bad;
    logic        wake_edge;
    logic        wr_data;
    logic        rd_data;
    logic        rd_status;
    logic        rd_int;
    logic [3:0]  events;

    baud_tick_gen u_baud (
        .clk          (SYS_CLK),
        .rst          (SYS_RST),
        .prescale_sel (prescale_sel),
        .divisor      (divisor),
        .tick         (sample_tick)
    );

    assign loopback = serial_format_control[`FMT_CHARL_LO]
                    & serial_format_control[`FMT_CHARL_HI];
    assign par_en   = serial_format_control[`FMT_PAR_EN] & ~loopback;
    assign ovs      = serial_format_control[`FMT_SYNC] ? `OVS_SYNC
                                                        : `OVS_ASYNC;
    assign half     = ovs >> 1;
    assign nbits    = dbits + {3'b000, par_en};
    assign wr_data  = REG_WE && REG_ADDR == `ADDR_DATA;
    assign rd_data  = REG_RE && REG_ADDR == `ADDR_DATA;
    assign rd_status = REG_RE && REG_ADDR == `ADDR_STATUS;
    assign rd_int   = REG_RE && REG_ADDR == `ADDR_INT_STATUS;
    assign tx_bit_tick = sample_tick && tx_phase == ovs - 5'h01;
    assign tx_load  = tx_state == uart_baud_pkg::TX_IDLE
                    && !transmit_buffer_empty_flag && !LOWPOWER_ENTER;
    assign SERIAL_TRANSMIT_PIN = transmit_shift_register[0];

    // character length 7, 8 or 9; the loopback code forces nine
    always_comb begin
        case (serial_format_control[1:0])
            2'b00:   dbits = 4'h7;
            2'b01:   dbits = 4'h8;
            default: dbits = 4'h9;
        endcase
    end

    // frame: start, data lsb first, optional parity, stop bits, idle ones
    always_comb begin
        next_frame = 12'hFFF;
        data_mask  = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < dbits) begin
                data_mask[i]      = 1'b1;
                next_frame[1 + i] = (i == 8)
                    ? serial_format_control[`FMT_XBIT9]
                    : transmit_holding_buffer[i];
            end
        end
        next_frame[0] = 1'b0;
        if (par_en) begin
            next_frame[4'h1 + dbits] =
                ^({serial_format_control[`FMT_XBIT9],
                   transmit_holding_buffer} & data_mask)
                ^ serial_format_control[`FMT_PAR_ODD];
        end
        next_len = 4'h2 + nbits
                 + {3'b000, serial_format_control[`FMT_STOP2]};
    end

    // received bits sit at the top of the shifter; align them to bit 0
    always_comb begin
        rx_word    = receive_shift_register >> (4'hA - nbits);
        rx_par_bad = par_en && ((^(rx_word[8:0] & data_mask))
                   ^ serial_format_control[`FMT_PAR_ODD]
                   ^ rx_word[dbits]) == 1'b1;
    end

    // control registers; low-power entry leaves them untouched
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            serial_format_control <= `FORMAT_RST;
            prescale_sel          <= `PRESCALE_RST;
            divisor               <= `DIVISOR_RST;
            int_mask              <= 4'h0;
            wake_enable_register  <= 8'h00;
            wake_edge_register    <= 8'h00;
        end else if (REG_WE) begin
            case (REG_ADDR)
                `ADDR_FORMAT:    serial_format_control <= REG_WDATA;
                `ADDR_PRESCALE:  prescale_sel <= REG_WDATA[4:0];
                `ADDR_DIVISOR:   divisor <= REG_WDATA;
                `ADDR_INT_MASK:  int_mask <= REG_WDATA[3:0];
                `ADDR_WAKE_EN:   wake_enable_register <= REG_WDATA;
                `ADDR_WAKE_EDGE: wake_edge_register <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // transmit holding buffer survives low-power entry
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            transmit_holding_buffer <= 8'h00;
        end else if (wr_data) begin
            transmit_holding_buffer <= REG_WDATA;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || LOWPOWER_ENTER) begin
            transmit_buffer_empty_flag <= 1'b1;
        end else if (wr_data) begin
            transmit_buffer_empty_flag <= 1'b0;
        end else if (tx_load) begin
            transmit_buffer_empty_flag <= 1'b1;
        end
    end

    // transmitter: one shift per bit time, ones fill in behind
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || LOWPOWER_ENTER) begin
            tx_state                <= uart_baud_pkg::TX_IDLE;
            transmit_shift_register <= 12'hFFF;
            tx_phase                <= 5'h00;
            tx_left                 <= 4'h0;
        end else begin
            case (tx_state)
                uart_baud_pkg::TX_IDLE: begin
                    if (tx_load) begin
                        transmit_shift_register <= next_frame;
                        tx_left                 <= next_len;
                        tx_phase                <= 5'h00;
                        tx_state                <= uart_baud_pkg::TX_SHIFT;
                    end
                end
                uart_baud_pkg::TX_SHIFT: begin
                    if (sample_tick) begin
                        tx_phase <= tx_bit_tick ? 5'h00 : tx_phase + 5'h01;
                    end
                    if (tx_bit_tick) begin
                        transmit_shift_register <=
                            {1'b1, transmit_shift_register[11:1]};
                        tx_left <= tx_left - 4'h1;
                        if (tx_left == 4'h1) begin
                            tx_state <= uart_baud_pkg::TX_IDLE;
                        end
                    end
                end
                default: tx_state <= uart_baud_pkg::TX_IDLE;
            endcase
        end
    end

    // receive pin synchroniser and edge history
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
            rx_prev  <= 1'b1;
        end else begin
            rx_sync1 <= SERIAL_RECEIVE_PIN;
            rx_sync2 <= rx_sync1;
            rx_prev  <= rx_sync2;
        end
    end

    assign rx_in = loopback ? transmit_shift_register[0] : rx_sync2;

    // receiver: find start, check it mid-bit, then sample each bit centre
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || LOWPOWER_ENTER) begin
            rx_state <= uart_baud_pkg::RX_IDLE;
            rx_phase <= 5'h00;
            rx_cnt   <= 4'h0;
        end else begin
            case (rx_state)
                uart_baud_pkg::RX_IDLE: begin
                    rx_phase <= 5'h00;
                    if (!rx_in) begin
                        rx_state <= uart_baud_pkg::RX_START;
                    end
                end
                uart_baud_pkg::RX_START: begin
                    if (sample_tick) begin
                        rx_phase <= rx_phase + 5'h01;
                        if (rx_phase >= half - 5'h01) begin
                            rx_phase <= 5'h00;
                            rx_cnt   <= 4'h0;
                            rx_state <= rx_in ? uart_baud_pkg::RX_IDLE
                                              : uart_baud_pkg::RX_DATA;
                        end
                    end
                end
                uart_baud_pkg::RX_DATA: begin
                    if (sample_tick) begin
                        rx_phase <= rx_phase + 5'h01;
                        if (rx_phase == ovs - 5'h01) begin
                            rx_phase <= 5'h00;
                            rx_cnt   <= rx_cnt + 4'h1;
                            if (rx_cnt == nbits - 4'h1) begin
                                rx_state <= uart_baud_pkg::RX_STOP;
                            end
                        end
                    end
                end
                uart_baud_pkg::RX_STOP: begin
                    if (sample_tick) begin
                        rx_phase <= rx_phase + 5'h01;
                        if (rx_phase == ovs - 5'h01) begin
                            rx_state <= uart_baud_pkg::RX_IDLE;
                        end
                    end
                end
                default: rx_state <= uart_baud_pkg::RX_IDLE;
            endcase
        end
    end

    assign rx_deliver = rx_state == uart_baud_pkg::RX_STOP && sample_tick
                     && rx_phase == ovs - 5'h01 && !LOWPOWER_ENTER;

    // receive shifter and holding buffer are kept over low-power entry
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            receive_shift_register <= 10'h000;
            receive_holding_buffer <= 8'h00;
        end else begin
            if (rx_state == uart_baud_pkg::RX_DATA && sample_tick
                && rx_phase == ovs - 5'h01 && !LOWPOWER_ENTER) begin
                receive_shift_register <=
                    {rx_in, receive_shift_register[9:1]};
            end
            if (rx_deliver) begin
                receive_holding_buffer <= rx_word[7:0];
            end
        end
    end

    // read-only status; hardware set wins over the read clear
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || LOWPOWER_ENTER) begin
            rbfl  <= 1'b0;
            perr  <= 1'b0;
            ferr  <= 1'b0;
            ovr   <= 1'b0;
            rbit9 <= 1'b0;
        end else begin
            rbfl <= rx_deliver | (rbfl & ~rd_data);
            perr <= (rx_deliver & rx_par_bad) | (perr & ~rd_status);
            ferr <= (rx_deliver & ~rx_in) | (ferr & ~rd_status);
            ovr  <= (rx_deliver & rbfl & ~rd_data) | (ovr & ~rd_status);
            if (rx_deliver) begin
                rbit9 <= dbits == 4'h9 && rx_word[8];
            end
        end
    end

    // low-power sequencing: sleep, start-bit wake, optional oscillator hold
    assign wake_edge = (wake_enable_register[`WAKE_RX_BIT]
                     & wake_edge_register[`WAKE_RX_BIT] & rx_prev & ~rx_sync2)
                     | (wake_enable_register[`WAKE_RX_BIT]
                     & ~wake_edge_register[`WAKE_RX_BIT]
                     & ~rx_prev & rx_sync2);

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pwr_state <= uart_baud_pkg::PWR_RUN;
            CODE_RUN  <= 1'b1;
            WAKE_UP   <= 1'b0;
            hold_cnt  <= 16'h0000;
            hold_halt <= 1'b0;
        end else begin
            WAKE_UP <= 1'b0;
            case (pwr_state)
                uart_baud_pkg::PWR_RUN: begin
                    if (LOWPOWER_ENTER) begin
                        hold_halt <= LOWPOWER_HALT & CRYSTAL_OSC;
                        CODE_RUN  <= 1'b0;
                        pwr_state <= uart_baud_pkg::PWR_SLEEP;
                    end
                end
                uart_baud_pkg::PWR_SLEEP: begin
                    if (wake_edge) begin
                        WAKE_UP  <= 1'b1;
                        hold_cnt <= 16'h0000;
                        if (hold_halt) begin
                            pwr_state <= uart_baud_pkg::PWR_HOLD;
                        end else begin
                            CODE_RUN  <= 1'b1;
                            pwr_state <= uart_baud_pkg::PWR_RUN;
                        end
                    end
                end
                uart_baud_pkg::PWR_HOLD: begin
                    hold_cnt <= hold_cnt + 16'h0001;
                    if (hold_cnt == 16'(WAKE_HOLD_CYCLES - 1)) begin
                        CODE_RUN  <= 1'b1;
                        pwr_state <= uart_baud_pkg::PWR_RUN;
                    end
                end
                default: begin
                    CODE_RUN  <= 1'b1;
                    pwr_state <= uart_baud_pkg::PWR_RUN;
                end
            endcase
        end
    end

    // sticky interrupt causes, cleared by reading them
    assign events = {WAKE_UP, rx_deliver & (rx_par_bad | ~rx_in | rbfl),
                     rx_deliver, tx_load};

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || LOWPOWER_ENTER) begin
            int_status <= 4'h0;
        end else begin
            int_status <= events | (int_status & {4{~rd_int}});
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_status & int_mask);
        end
    end

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !REG_RE) begin
            REG_RDATA <= 8'h00;
        end else begin
            case (REG_ADDR)
                `ADDR_DATA:       REG_RDATA <= receive_holding_buffer;
                `ADDR_FORMAT:     REG_RDATA <= serial_format_control;
                `ADDR_PRESCALE:   REG_RDATA <= {3'b000, prescale_sel};
                `ADDR_DIVISOR:    REG_RDATA <= divisor;
                `ADDR_STATUS:     REG_RDATA <= {2'b00, rbit9, ovr, ferr, perr,
                                        rbfl, transmit_buffer_empty_flag};
                `ADDR_INT_STATUS: REG_RDATA <= {4'h0, int_status};
                `ADDR_INT_MASK:   REG_RDATA <= {4'h0, int_mask};
                `ADDR_WAKE_EN:    REG_RDATA <= wake_enable_register;
                `ADDR_WAKE_EDGE:  REG_RDATA <= wake_edge_register;
                default:          REG_RDATA <= 8'h00;
            endcase
        end
    end
endmodule : uart_baud_lowpower_loopback

// ---- tb/uart_port_checker_assertions.sv ----
// port assertions of the uart low-power and wake behaviour
`timescale 1ns/10ps
module uart_port_checker #(
    parameter int WAKE_HOLD_CYCLES = 20
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic SERIAL_TRANSMIT_PIN,
    input wire logic LOWPOWER_ENTER,
    input wire logic LOWPOWER_HALT,
    input wire logic CRYSTAL_OSC,
    input wire logic WAKE_UP,
    input wire logic CODE_RUN,
    input wire logic IRQ
);
    logic hold;
    int   cnt;
    // remembers whether this sleep needs the oscillator hold-off
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST)
            hold <= 1'b0;
        else if (LOWPOWER_ENTER && CODE_RUN)
            hold <= LOWPOWER_HALT && CRYSTAL_OSC;
    end
    // cycles since the last wake pulse
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || WAKE_UP)
            cnt <= 1;
        else
            cnt <= cnt + 1;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    property p_tx_ones; LOWPOWER_ENTER |=> SERIAL_TRANSMIT_PIN[*3]; endproperty
    a_tx_ones: assert property (p_tx_ones) else $error("tx not idle");
    property p_irq_clr; LOWPOWER_ENTER |=> ##1 !IRQ; endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq kept");
    property p_sleep; LOWPOWER_ENTER && CODE_RUN |=> !CODE_RUN; endproperty
    a_sleep: assert property (p_sleep) else $error("still running");
    property p_woke; WAKE_UP |-> !$past(CODE_RUN); endproperty
    a_woke: assert property (p_woke) else $error("wake in run");
    property p_pulse; WAKE_UP |=> !WAKE_UP; endproperty
    a_pulse: assert property (p_pulse) else $error("wake too long");
    property p_run; WAKE_UP && !hold |-> CODE_RUN; endproperty
    a_run: assert property (p_run) else $error("no run on wake");
    property p_hold; WAKE_UP && hold |-> !CODE_RUN; endproperty
    a_hold: assert property (p_hold) else $error("no hold-off");
    property p_hold_len;
        $rose(CODE_RUN) && hold |-> cnt == WAKE_HOLD_CYCLES;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold len");
endmodule : uart_port_checker

bind uart_baud_lowpower_loopback uart_port_checker #(
    .WAKE_HOLD_CYCLES(WAKE_HOLD_CYCLES)
) u_chk (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .SERIAL_TRANSMIT_PIN(SERIAL_TRANSMIT_PIN),
    .LOWPOWER_ENTER(LOWPOWER_ENTER), .LOWPOWER_HALT(LOWPOWER_HALT),
    .CRYSTAL_OSC(CRYSTAL_OSC), .WAKE_UP(WAKE_UP),
    .CODE_RUN(CODE_RUN), .IRQ(IRQ)
);

// ---- tb/serial_peer.sv ----
// remote serial device on the transmit and receive pins
`timescale 1ns/10ps
module serial_peer (
    input  wire logic clk,
    input  wire logic tx_line,
    output logic      rx_line
);
    initial rx_line = 1'b1;
    task automatic park(input logic lvl);
        rx_line <= lvl;
    endtask : park
    // start bit, eight data bits lsb first, one stop bit
    task automatic send(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (bt) @(posedge clk);
        end
    endtask : send
    // width of the high run of a 0111_1110 frame, bounded waits
    task automatic recv(output int w);
        int n;
        n = 0;
        w = 0;
        while (tx_line !== 1'b0 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        while (tx_line !== 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        while (tx_line === 1'b1 && w < 9000) begin
            @(posedge clk);
            w++;
        end
        while (tx_line !== 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        // a used-up bound must show up as a wrong width
        if (n >= 9000) begin
            w = -1;
        end
    endtask : recv
endmodule : serial_peer

// ---- tb/uart_baud_lowpower_loopback_test.sv ----
// self-checking bench of baud rate, low power, wake and loopback
`timescale 1ns/10ps
`include "uart_baud_defs.svh"
module uart_baud_lowpower_loopback_test;
    localparam int HOLD = 20;
    localparam logic [4:0] CODES [4] = '{5'h01, 5'h1E, 5'h1F, 5'h03};
    localparam logic [7:0] DIVS [4] = '{8'h02, 8'h00, 8'h01, 8'h01};
    logic        SYS_CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [3:0]  REG_ADDR = 4'h0;
    logic [7:0]  REG_WDATA = 8'h00;
    logic        REG_WE = 1'b0;
    logic        REG_RE = 1'b0;
    logic        LOWPOWER_ENTER = 1'b0;
    logic        LOWPOWER_HALT = 1'b0;
    logic        CRYSTAL_OSC = 1'b0;
    logic [7:0]  REG_RDATA;
    logic        rx_pin;
    logic        tx_pin;
    logic        WAKE_UP;
    logic        CODE_RUN;
    logic        IRQ;
    logic [15:0] lfsr = 16'hC5FF;
    logic [7:0]  exp_q [$];
    logic [7:0]  v;
    int          errors = 0;
    int          checks_done = 0;
    int          w;
    int          bt;
    always #4 SYS_CLK = ~SYS_CLK;
    uart_baud_lowpower_loopback #(.WAKE_HOLD_CYCLES(HOLD)) u_dut (
        .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
        .REG_RDATA(REG_RDATA), .SERIAL_RECEIVE_PIN(rx_pin),
        .SERIAL_TRANSMIT_PIN(tx_pin), .LOWPOWER_ENTER(LOWPOWER_ENTER),
        .LOWPOWER_HALT(LOWPOWER_HALT), .CRYSTAL_OSC(CRYSTAL_OSC),
        .WAKE_UP(WAKE_UP), .CODE_RUN(CODE_RUN), .IRQ(IRQ)
    );
    serial_peer u_peer (.clk(SYS_CLK), .tx_line(tx_pin), .rx_line(rx_pin));
    function automatic logic [15:0] rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : rnd
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WE <= 1'b1;
        @(posedge SYS_CLK);
        REG_WE <= 1'b0;
        @(posedge SYS_CLK);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        REG_ADDR <= a;
        REG_RE <= 1'b1;
        @(posedge SYS_CLK);
        REG_RE <= 1'b0;
        @(posedge SYS_CLK);
        chk(16'(REG_RDATA), 16'(e));
    endtask : rd
    // enter low power, then wake through a start bit from the peer
    task automatic nap(input logic halt, input logic xtal);
        int n;
        int m;
        LOWPOWER_ENTER <= 1'b1;
        LOWPOWER_HALT <= halt;
        CRYSTAL_OSC <= xtal;
        @(posedge SYS_CLK);
        LOWPOWER_ENTER <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        chk(16'({CODE_RUN, tx_pin}), 16'h1);
        rd(`ADDR_STATUS, 8'h01);
        rd(`ADDR_FORMAT, 8'h4B);
        n = 0;
        m = 0;
        u_peer.park(1'b0);
        while (WAKE_UP !== 1'b1 && n < 100) begin
            @(posedge SYS_CLK);
            n++;
        end
        chk(16'(n < 100), 16'h1);
        while (CODE_RUN !== 1'b1 && m < 100) begin
            @(posedge SYS_CLK);
            m++;
        end
        chk(16'(m), halt && xtal ? 16'(HOLD) : 16'h0);
        u_peer.park(1'b1);
        repeat (4) @(posedge SYS_CLK);
    endtask : nap
    task automatic complete_run;
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        repeat (5) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        rd(`ADDR_STATUS, 8'h01);
        rd(`ADDR_FORMAT, `FORMAT_RST);
        rd(4'hF, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(`ADDR_FORMAT, k == 3 ? 8'h21 : 8'h01);
            wr(`ADDR_PRESCALE, {3'h0, CODES[k]});
            wr(`ADDR_DIVISOR, DIVS[k]);
            wr(`ADDR_DATA, 8'h7E);
            bt = (k == 3 ? 1 : 8) * (DIVS[k] + 1) * (CODES[k] + 1);
            u_peer.recv(w);
            chk(16'(w), 16'(6 * bt));
        end
        wr(`ADDR_FORMAT, 8'h01);
        wr(`ADDR_PRESCALE, 8'h01);
        wr(`ADDR_DIVISOR, 8'h00);
        lfsr = rnd(lfsr);
        u_peer.send(lfsr[7:0], 16);
        repeat (4) @(posedge SYS_CLK);
        rd(`ADDR_STATUS, 8'h03);
        rd(`ADDR_DATA, lfsr[7:0]);
        wr(`ADDR_FORMAT, 8'h4B);
        u_peer.park(1'b0);
        for (int j = 0; j < 2; j++) begin
            lfsr = rnd(lfsr);
            exp_q.push_back(lfsr[7:0]);
            wr(`ADDR_DATA, lfsr[7:0]);
            repeat (212) @(posedge SYS_CLK);
            if (j == 0) begin
                rd(`ADDR_STATUS, 8'h23);
                rd(`ADDR_DATA, exp_q.pop_front());
            end
        end
        chk(16'(IRQ), 16'h0);
        wr(`ADDR_INT_MASK, 8'h08);
        wr(`ADDR_WAKE_EN, 8'h08);
        wr(`ADDR_WAKE_EDGE, 8'h08);
        u_peer.park(1'b1);
        wr(`ADDR_DATA, 8'hA5);
        repeat (40) @(posedge SYS_CLK);
        nap(1'b0, 1'b1);
        chk(16'(IRQ), 16'h1);
        rd(`ADDR_INT_STATUS, 8'h08);
        repeat (2) @(posedge SYS_CLK);
        chk(16'(IRQ), 16'h0);
        rd(`ADDR_DATA, exp_q.pop_front());
        nap(1'b1, 1'b1);
        complete_run();
    end
endmodule : uart_baud_lowpower_loopback_test
